// ===== design/paged_status_consts.vh
// Constants for the paged status and test register group.
// Assumes inclusion by bare name from design files that need offsets and fields.
`ifndef PAGED_STATUS_CONSTS_VH
`define PAGED_STATUS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define IDX_PAGED_STATUS 8'h10
`define IDX_MEAS_SELECT 8'h11
`define IDX_TEST_SETTING 8'h12
`define ADDR_PAGED_STATUS (`IDX_PAGED_STATUS * 4)
`define ADDR_MEAS_SELECT (`IDX_MEAS_SELECT * 4)
`define ADDR_TEST_SETTING (`IDX_TEST_SETTING * 4)
`define ADDR_W 10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MEAS_SELECT_RESET 4'h0
`define TEST_SETTING_RESET 24'h000000

// ----------------------------------------------------------------------------
// Test setting fields
// ----------------------------------------------------------------------------
`define TS_CHECK_A_HI 23
`define TS_CHECK_A_LO 21
`define TS_CHECK_B_HI 20
`define TS_CHECK_B_LO 18
`define TS_PAGE_EXT 16
`define TS_PAGE_HI 15
`define TS_PAGE_LO 14
`define TS_TRIM_DIR 11
`define TS_SETTLE_BOOST 10
`define TS_DEC_VARIANT 7

// ----------------------------------------------------------------------------
// Status pages
// ----------------------------------------------------------------------------
`define PAGE_GAIN_LOOP 3'h0
`define PAGE_OSC_RANGE 3'h1
`define PAGE_FILTER_TRIM 3'h2
`define PAGE_PILOT_FREQ 3'h3

// ----------------------------------------------------------------------------
// Measurement source codes
// ----------------------------------------------------------------------------
`define MSEL_NONE 3'h0
`define MSEL_MIXER_I 3'h1
`define MSEL_ADC_PIN 3'h3
`define MSEL_RF_LEVEL 3'h4
`define MSEL_EXT_SUPPLY 3'h7
`define MSEL_W 4

`endif

// ===== design/pin_sync.v
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the levels change slowly relative to pclk; bits may resolve on
// different cycles, so a multi-bit status word can be briefly mixed.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_reg;

    // The first stage is read only by the second stage.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// ===== design/paged_status_test_regs.v
// Paged status, measurement select and test setting registers behind APB.
// Assumes an APB master on pclk; the chip enable pin and all analog status
// levels arrive asynchronously and are synchronised here before use.
`timescale 1ns/10ps
`default_nettype none
`include "paged_status_consts.vh"

// Summary of operation
// - Page 0 shows the in-phase gain-loop level in bits 5:3 and quadrature in bits 2:0.
// - Page 1 shows oscillator range in bits 7:4, oscillator type in bit 3, pin voltage in 2:0.
// - Page 2 shows the high-pass trim code in the upper nibble and low-pass in the lower.
// - Page 3 shows the full eight-bit pilot frequency measurement.
// - The page number is test-setting bit 16 above bits 15:14, covering pages 0 to 7; pages 4 to 7 read zero.
// - The measurement code routes the converter input to none, mixer, pin, RF or supply.
// - Measurement select clears to zero at reset or while chip enable is low.
// - The test-setting register clears to zero at reset or while chip enable is low.
// - Bit 11 steers trim writes to the high-pass code when set, else to the low-pass code.
// - Bit 10 makes the first-stage coupling settle twice as fast.
module paged_status_test_regs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire chip_enable,
    input wire [2:0] gain_loop_i,
    input wire [2:0] gain_loop_q,
    input wire [3:0] oscillator_range_info,
    input wire oscillator_type,
    input wire [2:0] oscillator_pin_voltage,
    input wire [3:0] highpass_trim_code,
    input wire [3:0] lowpass_trim_code,
    input wire [7:0] pilot_freq,
    output reg [2:0] adc_source_code,
    output reg adc_route_mixer_i,
    output reg adc_route_pin,
    output reg adc_route_rf_level,
    output reg adc_route_external_supply,
    output reg [2:0] status_page_select,
    output reg trim_write_direction,
    output reg coupling_settle_boost,
    output reg decoder_variant,
    output reg [2:0] analog_check_a,
    output reg [2:0] analog_check_b,
    output reg [23:0] test_setting_out
);

    // ------------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------------
    localparam STATUS_W = 32;

    wire chip_enable_sync;
    wire [STATUS_W-1:0] status_raw;
    wire [STATUS_W-1:0] status_sync;

    assign status_raw = {pilot_freq, highpass_trim_code, lowpass_trim_code,
                         oscillator_range_info, oscillator_type, oscillator_pin_voltage,
                         gain_loop_i, gain_loop_q, 2'b00};

    pin_sync #(
        .WIDTH(1)
    ) enable_sync_inst (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(chip_enable),
        .sync_out(chip_enable_sync)
    );

    pin_sync #(
        .WIDTH(STATUS_W)
    ) status_sync_inst (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(status_raw),
        .sync_out(status_sync)
    );

    wire [7:0] pilot_s;
    wire [3:0] hp_trim_s;
    wire [3:0] lp_trim_s;
    wire [3:0] osc_range_s;
    wire osc_type_s;
    wire [2:0] osc_volt_s;
    wire [2:0] gain_i_s;
    wire [2:0] gain_q_s;

    assign pilot_s = status_sync[31:24];
    assign hp_trim_s = status_sync[23:20];
    assign lp_trim_s = status_sync[19:16];
    assign osc_range_s = status_sync[15:12];
    assign osc_type_s = status_sync[11];
    assign osc_volt_s = status_sync[10:8];
    assign gain_i_s = status_sync[7:5];
    assign gain_q_s = status_sync[4:2];

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    reg [`MSEL_W-1:0] meas_select_reg;
    reg [`MSEL_W-1:0] meas_select_next;
    reg [23:0] test_setting_reg;
    reg [23:0] test_setting_next;

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire [`ADDR_W-1:0] addr_word;
    wire hit_status;
    wire hit_meas;
    wire hit_test;
    wire hit_any;
    wire access_wait;
    wire access_done;
    wire wr_done;

    assign addr_word = paddr[`ADDR_W-1:0];
    assign hit_status = (addr_word == `ADDR_PAGED_STATUS) && (paddr[31:`ADDR_W] == 0);
    assign hit_meas = (addr_word == `ADDR_MEAS_SELECT) && (paddr[31:`ADDR_W] == 0);
    assign hit_test = (addr_word == `ADDR_TEST_SETTING) && (paddr[31:`ADDR_W] == 0);
    assign hit_any = hit_status | hit_meas | hit_test;

    // One wait state: pready rises in the first access cycle, the transfer
    // completes on the second, so read data is captured one edge before write data is stored.
    assign access_wait = psel && penable && !pready;
    assign access_done = psel && penable && pready;
    assign wr_done = access_done && pwrite && !pslverr;

    // ------------------------------------------------------------------------
    // Paged status selection
    // ------------------------------------------------------------------------
    wire [2:0] page_live;
    reg [7:0] status_view;

    assign page_live = test_setting_reg[`TS_PAGE_EXT:`TS_PAGE_LO];

    always @* begin
        status_view = 8'h00;
        case (page_live)
            `PAGE_GAIN_LOOP: begin
                status_view = {2'b00, gain_i_s, gain_q_s};
            end
            `PAGE_OSC_RANGE: begin
                status_view = {osc_range_s, osc_type_s, osc_volt_s};
            end
            `PAGE_FILTER_TRIM: begin
                status_view = {hp_trim_s, lp_trim_s};
            end
            `PAGE_PILOT_FREQ: begin
                status_view = pilot_s;
            end
            default: begin
                status_view = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Write path with byte strobes
    // ------------------------------------------------------------------------
    always @* begin
        meas_select_next = meas_select_reg;
        test_setting_next = test_setting_reg;
        if (wr_done && hit_meas && pstrb[0]) begin
            meas_select_next = pwdata[`MSEL_W-1:0];
        end
        if (wr_done && hit_test) begin
            if (pstrb[0]) begin
                test_setting_next[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                test_setting_next[15:8] = pwdata[15:8];
            end
            if (pstrb[2]) begin
                test_setting_next[23:16] = pwdata[23:16];
            end
        end
        if (!chip_enable_sync) begin
            meas_select_next = `MEAS_SELECT_RESET;
        end
        if (!chip_enable_sync) begin
            test_setting_next = `TEST_SETTING_RESET;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_select_reg <= `MEAS_SELECT_RESET;
            test_setting_reg <= `TEST_SETTING_RESET;
        end else begin
            meas_select_reg <= meas_select_next;
            test_setting_reg <= test_setting_next;
        end
    end

    // ------------------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------------------
    reg [31:0] read_mux;

    always @* begin
        read_mux = 32'h00000000;
        if (hit_status) begin
            read_mux = {24'h000000, status_view};
        end else if (hit_meas) begin
            read_mux = {{(32 - `MSEL_W){1'b0}}, meas_select_reg};
        end else if (hit_test) begin
            read_mux = {8'h00, test_setting_reg};
        end
    end

    // Read data is captured at the pready edge, one cycle before completion;
    // a status level moving in that single cycle is not reflected.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (access_wait) begin
            pready <= 1'b1;
            pslverr <= !hit_any;
            prdata <= pwrite ? 32'h00000000 : read_mux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------------
    wire [2:0] msel_code;

    assign msel_code = meas_select_reg[2:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_source_code <= `MSEL_NONE;
            adc_route_mixer_i <= 1'b0;
            adc_route_pin <= 1'b0;
            adc_route_rf_level <= 1'b0;
            adc_route_external_supply <= 1'b0;
        end else begin
            adc_source_code <= msel_code;
            adc_route_mixer_i <= (msel_code == `MSEL_MIXER_I);
            adc_route_pin <= (msel_code == `MSEL_ADC_PIN);
            adc_route_rf_level <= (msel_code == `MSEL_RF_LEVEL);
            adc_route_external_supply <= (msel_code == `MSEL_EXT_SUPPLY);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_page_select <= `PAGE_GAIN_LOOP;
            trim_write_direction <= 1'b0;
            coupling_settle_boost <= 1'b0;
            decoder_variant <= 1'b0;
            analog_check_a <= 3'h0;
            analog_check_b <= 3'h0;
            test_setting_out <= `TEST_SETTING_RESET;
        end else begin
            status_page_select <= page_live;
            trim_write_direction <= test_setting_reg[`TS_TRIM_DIR];
            coupling_settle_boost <= test_setting_reg[`TS_SETTLE_BOOST];
            decoder_variant <= test_setting_reg[`TS_DEC_VARIANT];
            analog_check_a <= test_setting_reg[`TS_CHECK_A_HI:`TS_CHECK_A_LO];
            analog_check_b <= test_setting_reg[`TS_CHECK_B_HI:`TS_CHECK_B_LO];
            test_setting_out <= test_setting_reg;
        end
    end

endmodule
`default_nettype wire

// ===== sim/paged_status_props.sv
// Concurrent checks on the paged status and test register group.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/10ps
`default_nettype none

module paged_status_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire chip_enable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [2:0] adc_source_code,
    input wire adc_route_mixer_i,
    input wire adc_route_pin,
    input wire adc_route_rf_level,
    input wire adc_route_external_supply,
    input wire [2:0] status_page_select,
    input wire trim_write_direction,
    input wire coupling_settle_boost,
    input wire [23:0] test_setting_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Setup then access; the answer comes one wait state later.
    sequence setup_phase;
        psel && !penable ##1 psel && penable;
    endsequence
    // The enable pin passes two sync flops, the register and one output stage first.
    sequence enable_low;
        !chip_enable [*6];
    endsequence

    a_wait_state: assert property (setup_phase |-> !pready ##1 pready)
        else $error("access phase length wrong");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_data: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("error response malformed");
    a_idle_data: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside answer");
    a_route_onehot: assert property ($onehot0({adc_route_mixer_i, adc_route_pin,
        adc_route_rf_level, adc_route_external_supply}))
        else $error("more than one route");
    a_route_code: assert property (adc_route_external_supply |-> adc_source_code == 3'h7)
        else $error("supply route with wrong code");
    a_page_field: assert property (status_page_select == test_setting_out[16:14])
        else $error("page select mismatch");
    a_trim_dir: assert property (trim_write_direction == test_setting_out[11])
        else $error("trim direction mismatch");
    a_settle_boost: assert property (coupling_settle_boost == test_setting_out[10])
        else $error("settle boost mismatch");
    a_enable_clear: assert property (enable_low |->
        test_setting_out == 24'h000000 && adc_source_code == 3'h0)
        else $error("registers not cleared by enable");
endmodule

bind paged_status_test_regs paged_status_props paged_status_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .chip_enable(chip_enable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_source_code(adc_source_code), .adc_route_mixer_i(adc_route_mixer_i),
    .adc_route_pin(adc_route_pin), .adc_route_rf_level(adc_route_rf_level),
    .adc_route_external_supply(adc_route_external_supply),
    .status_page_select(status_page_select), .trim_write_direction(trim_write_direction),
    .coupling_settle_boost(coupling_settle_boost), .test_setting_out(test_setting_out)
);
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the paged status and test register group.
// Assumes the design answers APB with its own pready; status pins settle slowly.
`timescale 1ns/10ps
`default_nettype none
`include "paged_status_consts.vh"

module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chip_enable, otype;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [2:0] gi, gq, opv, code, tpage;
    logic [3:0] ori, hp, lp, pstrb, strb;
    wire [3:0] route;
    logic dv;
    logic [2:0] ca, cb;
    logic [7:0] pf;
    logic [23:0] ts_out;
    logic trim_dir, boost, rerr;
    logic [7:0] page_exp [0:3];
    logic [2:0] codes [0:5];
    logic [3:0] routes [0:5];
    int err_total = 0, num_checks = 0, cyc = 0;

    paged_status_test_regs paged_status_test_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chip_enable(chip_enable), .gain_loop_i(gi), .gain_loop_q(gq),
        .oscillator_range_info(ori), .oscillator_type(otype), .oscillator_pin_voltage(opv),
        .highpass_trim_code(hp), .lowpass_trim_code(lp), .pilot_freq(pf),
        .adc_source_code(code), .adc_route_mixer_i(route[0]), .adc_route_pin(route[1]),
        .adc_route_rf_level(route[2]), .adc_route_external_supply(route[3]),
        .status_page_select(tpage), .trim_write_direction(trim_dir),
        .coupling_settle_boost(boost), .decoder_variant(dv), .analog_check_a(ca),
        .analog_check_b(cb), .test_setting_out(ts_out)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task end_sim;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The request is held until the edge where pready is seen high.
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            err_total++;
            $display("unexpected at %0t: timeout", $time);
            end_sim();
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pstrb, strb} = 8'hFF;
        presetn = 1'b0;
        chip_enable = 1'b1;
        {gi, gq, ori, otype, opv} = {3'h5, 3'h2, 4'hA, 1'b1, 3'h6};
        {hp, lp, pf} = {4'hC, 4'h3, 8'hA0};
        page_exp = '{8'h2A, 8'hAE, 8'hC3, 8'hA0};
        codes = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h7, 3'h2};
        routes = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(0, `ADDR_MEAS_SELECT, 0); chk(rd, 0);
        apb(0, `ADDR_TEST_SETTING, 0); chk(rd, 0);
        for (int p = 0; p < 4; p++) begin
            apb(1, `ADDR_TEST_SETTING, p << 14);
            apb(0, `ADDR_PAGED_STATUS, 0); chk(rd, {24'h0, page_exp[p]});
            chk(tpage, p);
        end
        apb(1, `ADDR_PAGED_STATUS, 32'h000000FF); chk(rerr, 0);
        apb(0, `ADDR_PAGED_STATUS, 0); chk(rd, 32'h000000A0);
        apb(1, `ADDR_TEST_SETTING, 32'h00000C00);
        apb(0, `ADDR_TEST_SETTING, 0); chk(rd, 32'h00000C00);
        chk({trim_dir, boost}, 2'b11);
        chk({dv, ca, cb}, 7'h00);
        apb(1, `ADDR_TEST_SETTING, 32'h00000400);
        repeat (2) @(posedge pclk);
        chk({trim_dir, boost}, 2'b01);
        strb = 4'h4;
        apb(1, `ADDR_TEST_SETTING, 32'h0001C800);
        strb = 4'hF;
        apb(0, `ADDR_TEST_SETTING, 0); chk(rd, 32'h00010400);
        apb(0, `ADDR_PAGED_STATUS, 0); chk(rd, 32'h00000000);
        chk(tpage, 3'h4);
        for (int i = 0; i < 6; i++) begin
            apb(1, `ADDR_MEAS_SELECT, codes[i]);
            repeat (2) @(posedge pclk);
            chk({code, route}, {codes[i], routes[i]});
        end
        apb(0, 32'h0000004C, 0); chk({rerr, rd}, {1'b1, 32'h0});
        apb(1, `ADDR_TEST_SETTING, 32'h00C400);
        apb(1, `ADDR_MEAS_SELECT, 32'h7);
        apb(0, `ADDR_MEAS_SELECT, 0); chk(rd, 32'h7);
        chk({tpage, boost}, 4'h7);
        chip_enable <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1, `ADDR_TEST_SETTING, 32'h00000400);
        apb(0, `ADDR_MEAS_SELECT, 0); chk(rd, 0);
        apb(0, `ADDR_TEST_SETTING, 0); chk(rd, 0);
        chk(ts_out, 0);
        end_sim();
    end
endmodule
`default_nettype wire
